// file: rtl/reset_bank_pkg.sv
// Constants, register layout and carrier types for the reset init bank.
// Assumes one core clock; reset kind and wake events arrive from logic
// on that same clock.
// Overview of operation
// - An interrupt wake with global enable set loads vector 0004h once the next instruction finishes.
// - Every wake-up raises at least one interrupt-control or peripheral-1 flag naming its source.
// - A brown-out or power-on reset clears power control bit 0; pin and watchdog resets leave it alone.
// - Address 93h reaches the address mask only in serial mode 1001, else the slave address.
// - Unimplemented bits always read as zero.
// - A reset accompanied by supply loss applies the power-on values.
// - The timer-2 period loads all ones on every reset and every wake-up.
// - Port direction registers load all ones on every reset and hold on wake-up.
// - Transmit status/control loads 0000 -010 on every reset and holds on wake-up.
// - Oscillator control loads -110 q000, q from the clock state, and holds on wake-up.
// - Conversion result and capture-2 value clear to zero after power-on and otherwise hold.
// - Power control reads 010x after power-on and holds on wake-up.
// - Watchdog control loads 0 1000 on every reset and holds on wake-up.
// - Port-B pull-up enable loads all ones on every reset and holds on wake-up.
package reset_bank_pkg;
    typedef enum logic [1:0] {
        RK_POWER_ON, RK_EXT_PIN, RK_WATCHDOG, RK_BROWN_OUT
    } reset_kind_e;
    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_s;
    typedef struct packed {
        logic [7:0] irq_control;
        logic [7:0] periph_flags;
    } wake_flags_s;
    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] por;
        logic [7:0] oth;
        logic [7:0] mask;
        logic       keep_oth;
        logic       wake_ones;
    } reg_desc_s;
    localparam int NUM_REGS = 34;
    localparam logic [8:0] ADDR_OPTION_ALIAS = 9'h181;
    localparam logic [8:0] ADDR_DIR_B_ALIAS  = 9'h186;
    localparam logic [8:0] ADDR_IRQ_STATUS   = 9'h1f0;
    localparam logic [8:0] ADDR_IRQ_MASK     = 9'h1f1;
    localparam logic [3:0] SSP_MASK_MODE     = 4'h9;
    localparam logic [12:0] IRQ_VECTOR       = 13'h0004;
    localparam logic [7:0] PWR_CTL_POR       = 8'h10;
    localparam int PWR_BOR_BIT  = 0;
    localparam int PWR_ULP_BIT  = 5;
    localparam int PWR_SBO_BIT  = 4;
    localparam int OSC_Q_BIT    = 3;
    localparam int IDX_CAP2_HIGH = 0;
    localparam int IDX_RESULT_HIGH = 2;
    localparam int IDX_DIR_A = 5;
    localparam int IDX_PWR_CTL = 12;
    localparam int IDX_OSC   = 13;
    localparam int IDX_PERIOD = 16;
    localparam int IDX_SADDR = 17;
    localparam int IDX_SMASK = 18;
    localparam int IDX_TX_STATUS = 23;
    localparam int IDX_PULLUP = 20;
    localparam int IDX_WDT   = 31;
    localparam int IRQ_BITS  = 5;
    localparam reg_desc_s REG_TABLE [NUM_REGS] = '{
        '{9'h01c, 8'h00, 8'h00, 8'hff, 1'b1, 1'b0},
        '{9'h01d, 8'h00, 8'h00, 8'h3f, 1'b0, 1'b0},
        '{9'h01e, 8'h00, 8'h00, 8'hff, 1'b1, 1'b0},
        '{9'h01f, 8'h00, 8'h00, 8'hdf, 1'b0, 1'b0},
        '{9'h081, 8'hff, 8'hff, 8'hff, 1'b0, 1'b0},
        '{9'h085, 8'hff, 8'hff, 8'hff, 1'b0, 1'b0},
        '{9'h086, 8'hff, 8'hff, 8'hff, 1'b0, 1'b0},
        '{9'h087, 8'hff, 8'hff, 8'hff, 1'b0, 1'b0},
        '{9'h088, 8'hff, 8'hff, 8'hff, 1'b0, 1'b0},
        '{9'h089, 8'h0f, 8'h0f, 8'h0f, 1'b0, 1'b0},
        '{9'h08c, 8'h00, 8'h00, 8'hff, 1'b0, 1'b0},
        '{9'h08d, 8'h00, 8'h00, 8'hff, 1'b0, 1'b0},
        '{9'h08e, 8'h10, 8'h00, 8'h33, 1'b1, 1'b0},
        '{9'h08f, 8'h60, 8'h60, 8'h7f, 1'b0, 1'b0},
        '{9'h090, 8'h00, 8'h00, 8'h1f, 1'b1, 1'b0},
        '{9'h091, 8'h00, 8'h00, 8'hff, 1'b0, 1'b0},
        '{9'h092, 8'hff, 8'hff, 8'hff, 1'b0, 1'b1},
        '{9'h093, 8'h00, 8'h00, 8'hff, 1'b0, 1'b0},
        '{9'h093, 8'hff, 8'hff, 8'hff, 1'b0, 1'b1},
        '{9'h094, 8'h00, 8'h00, 8'hff, 1'b0, 1'b0},
        '{9'h095, 8'hff, 8'hff, 8'hff, 1'b0, 1'b0},
        '{9'h096, 8'h00, 8'h00, 8'hff, 1'b0, 1'b0},
        '{9'h097, 8'h00, 8'h00, 8'hff, 1'b0, 1'b0},
        '{9'h098, 8'h02, 8'h02, 8'hf7, 1'b0, 1'b0},
        '{9'h099, 8'h00, 8'h00, 8'hff, 1'b0, 1'b0},
        '{9'h09a, 8'h00, 8'h00, 8'hff, 1'b0, 1'b0},
        '{9'h09b, 8'h00, 8'h00, 8'hff, 1'b0, 1'b0},
        '{9'h09c, 8'h00, 8'h00, 8'hff, 1'b0, 1'b0},
        '{9'h09d, 8'h01, 8'h01, 8'h1f, 1'b0, 1'b0},
        '{9'h09e, 8'h00, 8'h00, 8'hff, 1'b1, 1'b0},
        '{9'h09f, 8'h00, 8'h00, 8'hb0, 1'b0, 1'b0},
        '{9'h105, 8'h08, 8'h08, 8'h1f, 1'b0, 1'b0},
        '{9'h107, 8'h00, 8'h00, 8'hfb, 1'b0, 1'b0},
        '{9'h108, 8'h00, 8'h00, 8'hfb, 1'b0, 1'b0}
    };
endpackage

// file: rtl/reset_init_value_bank.sv
// Special-function register bank with per-reset-kind initial values.
// Assumes the reset unit, wake logic and core all run on core_clk, so
// their inputs need no synchroniser; rst is held while the unit resets.
`timescale 1ns/1ns
module reset_init_value_bank
    import reset_bank_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // core register port
    input  wire bus_req_s    bus_req,
    output logic [7:0]       rdata_q,
    // reset unit
    input  wire reset_kind_e reset_kind,
    input  wire logic        supply_lost,
    input  wire logic        osc_clock_ready,
    // wake and core status
    input  wire logic        wake_pulse,
    input  wire logic        wake_by_irq,
    input  wire wake_flags_s wake_flags,
    input  wire logic        global_irq_enable,
    input  wire logic        instr_done,
    input  wire logic [3:0]  serial_port_mode_field,
    // core side results
    output logic             pc_load_q,
    output logic [12:0]      pc_vector_q,
    output wake_flags_s      flag_set_q,
    output logic             irq_q
);

    typedef enum {VEC_IDLE, VEC_WAIT} vec_state_e;

    logic [7:0]          regs_q [NUM_REGS];
    logic [NUM_REGS-1:0] hit;
    logic [7:0]          rd_val;
    logic [IRQ_BITS-1:0] status_q;
    logic [IRQ_BITS-1:0] status_d;
    logic [IRQ_BITS-1:0] mask_q;
    logic [IRQ_BITS-1:0] events;
    vec_state_e          vec_q;
    vec_state_e          vec_d;
    wake_flags_s         flags_d;

    wire logic [8:0] addr_n;
    wire logic       mask_sel;
    wire logic       por_eff;
    wire logic       bor_eff;
    wire logic       hit_status;
    wire logic       hit_mask;
    wire logic       vec_fire;
    wire logic       vec_arm;

    // both aliased addresses fold onto their bank-1 home
    function automatic logic [8:0] fold_alias(logic [8:0] a);
        if (a == ADDR_OPTION_ALIAS) begin
            return REG_TABLE[4].addr;
        end
        if (a == ADDR_DIR_B_ALIAS) begin
            return REG_TABLE[6].addr;
        end
        return a;
    endfunction

    assign addr_n     = fold_alias(bus_req.addr);
    assign mask_sel   = (serial_port_mode_field == SSP_MASK_MODE);
    // a deep supply dip turns any reset into a power-on one
    assign por_eff    = (reset_kind == RK_POWER_ON) || supply_lost;
    assign bor_eff    = (reset_kind == RK_BROWN_OUT) && !por_eff;
    assign hit_status = (bus_req.addr == ADDR_IRQ_STATUS);
    assign hit_mask   = (bus_req.addr == ADDR_IRQ_MASK);
    assign vec_arm    = wake_pulse && wake_by_irq && global_irq_enable;
    assign vec_fire   = (vec_q == VEC_WAIT) && instr_done;

    // address decode, with 93h steered by the serial mode
    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            hit[i] = (addr_n == REG_TABLE[i].addr);
        end
        hit[IDX_SADDR] = hit[IDX_SADDR] && !mask_sel;
        hit[IDX_SMASK] = hit[IDX_SMASK] && mask_sel;
    end

    // read mux; masking keeps unimplemented bits at zero
    always_comb begin
        rd_val = 8'h00;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (hit[i]) begin
                rd_val = rd_val | (regs_q[i] & REG_TABLE[i].mask);
            end
        end
        if (hit_status) begin
            rd_val = {3'h0, status_q};
        end
        if (hit_mask) begin
            rd_val = {3'h0, mask_q};
        end
    end

    // register file: reset kind, wake load, software write
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < NUM_REGS; i++) begin
            if (rst) begin
                if (por_eff) begin
                    regs_q[i] <= REG_TABLE[i].por;
                end else if (!REG_TABLE[i].keep_oth) begin
                    regs_q[i] <= REG_TABLE[i].oth;
                end
            end else if (wake_pulse && REG_TABLE[i].wake_ones) begin
                regs_q[i] <= REG_TABLE[i].mask;
            end else if (bus_req.wr && hit[i]) begin
                regs_q[i] <= bus_req.wdata & REG_TABLE[i].mask;
            end
        end
        if (rst && !por_eff) begin
            regs_q[IDX_PWR_CTL][PWR_ULP_BIT] <= 1'b0;
            if (bor_eff) begin
                regs_q[IDX_PWR_CTL][PWR_SBO_BIT] <= 1'b1;
                regs_q[IDX_PWR_CTL][PWR_BOR_BIT] <= 1'b0;
            end
        end
        // clock-state bit is captured at reset, not writable
        if (rst) begin
            regs_q[IDX_OSC][OSC_Q_BIT] <= osc_clock_ready;
        end else if (bus_req.wr && hit[IDX_OSC]) begin
            regs_q[IDX_OSC][OSC_Q_BIT] <= regs_q[IDX_OSC][OSC_Q_BIT];
        end
    end

    // read data stands for one cycle only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= bus_req.rd ? rd_val : 8'h00;
        end
    end

    // wake flags: forward the cause, never leave it empty
    always_comb begin
        flags_d = '0;
        if (wake_pulse) begin
            flags_d = wake_flags;
            if (wake_flags == '0) begin
                flags_d.irq_control[0] = 1'b1;
            end
        end
    end

    // vector load waits for the instruction after the wake
    always_comb begin
        vec_d = vec_q;
        case (vec_q)
            VEC_IDLE: begin
                if (vec_arm) begin
                    vec_d = VEC_WAIT;
                end
            end
            VEC_WAIT: begin
                if (instr_done) begin
                    vec_d = VEC_IDLE;
                end
            end
            default: begin
                vec_d = VEC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            vec_q       <= VEC_IDLE;
            pc_load_q   <= 1'b0;
            pc_vector_q <= 13'h0000;
            flag_set_q  <= '0;
        end else begin
            vec_q       <= vec_d;
            pc_load_q   <= vec_fire;
            pc_vector_q <= vec_fire ? IRQ_VECTOR : 13'h0000;
            flag_set_q  <= flags_d;
        end
    end

    // sticky events: por, bor, irq wake, wdt wake, vector load
    assign events = {vec_fire, wake_pulse && !wake_by_irq,
                     wake_pulse && wake_by_irq, 1'b0, 1'b0};

    // a fresh event beats a write-one clear in the same cycle
    always_comb begin
        status_d = status_q;
        if (bus_req.wr && hit_status) begin
            status_d = status_q & ~bus_req.wdata[IRQ_BITS-1:0];
        end
        status_d = status_d | events;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            status_q <= {3'h0, bor_eff, por_eff};
            mask_q   <= '0;
            irq_q    <= 1'b0;
        end else begin
            status_q <= status_d;
            if (bus_req.wr && hit_mask) begin
                mask_q <= bus_req.wdata[IRQ_BITS-1:0];
            end
            irq_q <= |(status_d & (bus_req.wr && hit_mask ?
                     bus_req.wdata[IRQ_BITS-1:0] : mask_q));
        end
    end

    property p_vector_load;
        @(posedge core_clk) disable iff (rst)
        (vec_q == VEC_WAIT) && instr_done |=>
            pc_load_q && (pc_vector_q == 13'h0004) ##1 !pc_load_q;
    endproperty
    a_vector_load: assert property (p_vector_load)
        else $error("vector not loaded after instruction");

    property p_wake_flag;
        @(posedge core_clk) disable iff (rst)
        wake_pulse |=>
            (flag_set_q.irq_control | flag_set_q.periph_flags) != 8'h00;
    endproperty
    a_wake_flag: assert property (p_wake_flag)
        else $error("wake raised no source flag");

    property p_bor_bit;
        @(posedge core_clk)
        $fell(rst) && $past(reset_kind == RK_BROWN_OUT)
            && !$past(supply_lost) |-> !regs_q[IDX_PWR_CTL][PWR_BOR_BIT];
    endproperty
    a_bor_bit: assert property (p_bor_bit)
        else $error("brown-out did not clear power bit 0");

    property p_mask_select;
        @(posedge core_clk) disable iff (rst)
        bus_req.rd && (bus_req.addr == 9'h093) |=>
            rdata_q == ($past(mask_sel) ? $past(regs_q[IDX_SMASK])
                                        : $past(regs_q[IDX_SADDR]));
    endproperty
    a_mask_select: assert property (p_mask_select)
        else $error("93h steered to the wrong register");

    property p_unimpl_zero;
        @(posedge core_clk) disable iff (rst)
        bus_req.rd && (bus_req.addr == 9'h098) |=> rdata_q[3] == 1'b0;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented bit read as one");

    property p_power_loss;
        @(posedge core_clk)
        $fell(rst) && $past(supply_lost) |->
            regs_q[IDX_PWR_CTL] == PWR_CTL_POR
            && regs_q[IDX_CAP2_HIGH] == 8'h00;
    endproperty
    a_power_loss: assert property (p_power_loss)
        else $error("supply loss did not give power-on values");

    property p_period_wake;
        @(posedge core_clk) disable iff (rst)
        wake_pulse |=> regs_q[IDX_PERIOD] == 8'hff;
    endproperty
    a_period_wake: assert property (p_period_wake)
        else $error("period not all ones after wake");

    property p_dir_hold;
        @(posedge core_clk) disable iff (rst)
        wake_pulse && !bus_req.wr |=> $stable(regs_q[IDX_DIR_A]);
    endproperty
    a_dir_hold: assert property (p_dir_hold)
        else $error("direction changed on wake");

    property p_init_values;
        @(posedge core_clk)
        $fell(rst) |-> regs_q[IDX_DIR_A] == 8'hff
            && regs_q[IDX_TX_STATUS] == 8'h02 && regs_q[IDX_WDT] == 8'h08
            && regs_q[IDX_PULLUP] == 8'hff;
    endproperty
    a_init_values: assert property (p_init_values)
        else $error("reset values missing at release");

    property p_osc_reset;
        @(posedge core_clk)
        $fell(rst) |-> regs_q[IDX_OSC] ==
            {4'b0110, $past(osc_clock_ready), 3'b000};
    endproperty
    a_osc_reset: assert property (p_osc_reset)
        else $error("oscillator control reset value wrong");

    property p_result_hold;
        @(posedge core_clk)
        rst && !por_eff ##1 !rst |-> $stable(regs_q[IDX_RESULT_HIGH]);
    endproperty
    a_result_hold: assert property (p_result_hold)
        else $error("result changed on non-power reset");

    property p_pwr_por;
        @(posedge core_clk)
        $fell(rst) && $past(reset_kind == RK_POWER_ON) |->
            regs_q[IDX_PWR_CTL][5:1] == 5'b01000;
    endproperty
    a_pwr_por: assert property (p_pwr_por)
        else $error("power control not 010x after power-on");

    property p_irq_level;
        @(posedge core_clk) disable iff (rst)
        ##1 irq_q == |($past(status_d) & mask_q);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level disagrees with status");

    property p_flag_pulse;
        @(posedge core_clk) disable iff (rst)
        !wake_pulse |=> flag_set_q == '0;
    endproperty
    a_flag_pulse: assert property (p_flag_pulse)
        else $error("wake flags stood longer than one cycle");

    property p_bor_keep;
        @(posedge core_clk)
        rst && !por_eff && (reset_kind != RK_BROWN_OUT) |=>
            $stable(regs_q[IDX_PWR_CTL][PWR_BOR_BIT]);
    endproperty
    a_bor_keep: assert property (p_bor_keep)
        else $error("non-brown-out reset touched power bit 0");

    property p_read_stands;
        @(posedge core_clk) disable iff (rst)
        !bus_req.rd |=> rdata_q == 8'h00;
    endproperty
    a_read_stands: assert property (p_read_stands)
        else $error("read data stood without a read strobe");

    property p_osc_locked;
        @(posedge core_clk) disable iff (rst)
        bus_req.wr && hit[IDX_OSC] |=> $stable(regs_q[IDX_OSC][OSC_Q_BIT]);
    endproperty
    a_osc_locked: assert property (p_osc_locked)
        else $error("clock-state bit changed by a write");

    property p_capture_keep;
        @(posedge core_clk)
        rst && !por_eff |=> $stable(regs_q[IDX_CAP2_HIGH]);
    endproperty
    a_capture_keep: assert property (p_capture_keep)
        else $error("capture value changed on non-power reset");

    property p_tx_wake_hold;
        @(posedge core_clk) disable iff (rst)
        wake_pulse && !bus_req.wr |=> $stable(regs_q[IDX_TX_STATUS]);
    endproperty
    a_tx_wake_hold: assert property (p_tx_wake_hold)
        else $error("transmit status changed on wake");

    property p_pwr_wake_hold;
        @(posedge core_clk) disable iff (rst)
        wake_pulse && !bus_req.wr |=> $stable(regs_q[IDX_PWR_CTL]);
    endproperty
    a_pwr_wake_hold: assert property (p_pwr_wake_hold)
        else $error("power control changed on wake");

    property p_wdt_wake_hold;
        @(posedge core_clk) disable iff (rst)
        wake_pulse && !bus_req.wr |=> $stable(regs_q[IDX_WDT]);
    endproperty
    a_wdt_wake_hold: assert property (p_wdt_wake_hold)
        else $error("watchdog control changed on wake");

    property p_pullup_wake_hold;
        @(posedge core_clk) disable iff (rst)
        wake_pulse && !bus_req.wr |=> $stable(regs_q[IDX_PULLUP]);
    endproperty
    a_pullup_wake_hold: assert property (p_pullup_wake_hold)
        else $error("pull-up enable changed on wake");

endmodule

// file: verification/core_model.sv
// Processor-core model: drives the register port and the wake inputs.
// Assumes the bank answers reads in the cycle after the read strobe.
`timescale 1ns/1ns
module core_model
    import reset_bank_pkg::*;
(
    // clock
    input  wire logic        core_clk,
    // register port
    output bus_req_s         bus_req,
    input  wire logic [7:0]  rdata_q,
    // wake and core status
    output logic             wake_pulse,
    output logic             wake_by_irq,
    output wake_flags_s      wake_flags,
    output logic             global_irq_enable,
    output logic             instr_done,
    output logic [3:0]       serial_port_mode_field
);
    initial begin
        bus_req = '0;
        wake_pulse = 1'b0;
        wake_by_irq = 1'b0;
        wake_flags = '0;
        global_irq_enable = 1'b0;
        instr_done = 1'b0;
        serial_port_mode_field = 4'h0;
    end
    task automatic bus_write(input logic [8:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask
    // data is taken only in the one cycle it stands
    task automatic bus_read(input logic [8:0] a, output logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1;
        d = rdata_q;
    endtask
    task automatic wake(input logic irq, input logic irq_en,
                        input logic [15:0] f);
        @(posedge core_clk);
        wake_pulse <= 1'b1;
        wake_by_irq <= irq;
        global_irq_enable <= irq_en;
        wake_flags <= f;
        @(posedge core_clk);
        wake_pulse <= 1'b0;
        #1;
    endtask
    task automatic instr_pulse();
        @(posedge core_clk);
        instr_done <= 1'b1;
        @(posedge core_clk);
        instr_done <= 1'b0;
        #1;
    endtask
    task automatic set_mode(input logic [3:0] m);
        @(posedge core_clk);
        serial_port_mode_field <= m;
    endtask
endmodule

// file: verification/test_reset_init_value_bank.sv
// Self-checking bench for the reset init bank.
// Assumes core_model drives every core-side input of the bank.
`timescale 1ns/1ns
module test_reset_init_value_bank;
    import reset_bank_pkg::*;
    logic        core_clk;
    logic        rst;
    reset_kind_e reset_kind;
    logic        supply_lost;
    logic        osc_clock_ready;
    bus_req_s    bus_req;
    logic [7:0]  rdata_q;
    logic        wake_pulse;
    logic        wake_by_irq;
    wake_flags_s wake_flags;
    logic        global_irq_enable;
    logic        instr_done;
    logic [3:0]  serial_port_mode_field;
    logic        pc_load_q;
    logic [12:0] pc_vector_q;
    wake_flags_s flag_set_q;
    logic        irq_q;
    int          n_mismatch = 0;
    int          comparisons = 0;

    reset_init_value_bank u_reset_init_value_bank (
        .core_clk(core_clk), .rst(rst), .bus_req(bus_req),
        .rdata_q(rdata_q), .reset_kind(reset_kind),
        .supply_lost(supply_lost), .osc_clock_ready(osc_clock_ready),
        .wake_pulse(wake_pulse), .wake_by_irq(wake_by_irq),
        .wake_flags(wake_flags), .global_irq_enable(global_irq_enable),
        .instr_done(instr_done),
        .serial_port_mode_field(serial_port_mode_field),
        .pc_load_q(pc_load_q), .pc_vector_q(pc_vector_q),
        .flag_set_q(flag_set_q), .irq_q(irq_q)
    );
    core_model u_core_model (
        .core_clk(core_clk), .bus_req(bus_req), .rdata_q(rdata_q),
        .wake_pulse(wake_pulse), .wake_by_irq(wake_by_irq),
        .wake_flags(wake_flags), .global_irq_enable(global_irq_enable),
        .instr_done(instr_done),
        .serial_port_mode_field(serial_port_mode_field)
    );

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic report_and_stop();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_core_model.bus_read(a, d);
        chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, d});
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        u_core_model.bus_write(a, d);
    endtask
    // reset held a few cycles; values must be in place at release
    task automatic do_reset(input reset_kind_e k, input logic lost);
        @(posedge core_clk);
        rst <= 1'b1;
        reset_kind <= k;
        supply_lost <= lost;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
    endtask

    initial begin
        #80000;
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        rst = 1'b1;
        reset_kind = RK_POWER_ON;
        supply_lost = 1'b0;
        osc_clock_ready = 1'b1;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        rd(9'h092, 8'hff);
        rd(9'h085, 8'hff);
        rd(9'h098, 8'h02);
        rd(9'h08f, 8'h68);
        rd(9'h08e, 8'h10);
        rd(9'h105, 8'h08);
        rd(9'h095, 8'hff);
        rd(9'h01e, 8'h00);
        rd(9'h1f0, 8'h01);
        rd(9'h000, 8'h00);
        rd(9'h181, 8'hff);
        wr(9'h186, 8'h3c);
        rd(9'h086, 8'h3c);
        wr(9'h08f, 8'hf7);
        rd(9'h08f, 8'h7f);
        rd(9'h093, 8'h00);
        u_core_model.set_mode(4'h9);
        rd(9'h093, 8'hff);
        wr(9'h093, 8'h77);
        rd(9'h093, 8'h77);
        u_core_model.set_mode(4'h0);
        rd(9'h093, 8'h00);
        wr(9'h098, 8'hff);
        rd(9'h098, 8'hf7);
        wr(9'h105, 8'hff);
        rd(9'h105, 8'h1f);
        wr(9'h01e, 8'h5a);
        wr(9'h085, 8'h12);
        wr(9'h08e, 8'h03);
        wr(9'h092, 8'h34);
        wr(9'h095, 8'h00);
        rd(9'h092, 8'h34);
        // watchdog wake with no flags still names a source
        u_core_model.wake(1'b0, 1'b0, 16'h0000);
        chk("flag_set_q", 16'h0100, flag_set_q);
        rd(9'h092, 8'hff);
        rd(9'h085, 8'h12);
        rd(9'h095, 8'h00);
        rd(9'h098, 8'hf7);
        rd(9'h105, 8'h1f);
        rd(9'h01e, 8'h5a);
        rd(9'h08e, 8'h03);
        rd(9'h08f, 8'h7f);
        u_core_model.wake(1'b1, 1'b0, 16'h0001);
        u_core_model.instr_pulse();
        chk("pc_load_q", 16'h0000, {15'h0, pc_load_q});
        wr(9'h1f1, 8'h04);
        u_core_model.wake(1'b1, 1'b1, 16'h0020);
        chk("flag_set_q", 16'h0020, flag_set_q);
        chk("irq_q", 16'h0001, {15'h0, irq_q});
        u_core_model.instr_pulse();
        chk("pc_load_q", 16'h0001, {15'h0, pc_load_q});
        chk("pc_vector_q", 16'h0004, {3'h0, pc_vector_q});
        wr(9'h1f0, 8'h04);
        @(posedge core_clk);
        #1;
        chk("irq_q", 16'h0000, {15'h0, irq_q});
        @(posedge core_clk);
        osc_clock_ready <= 1'b0;
        do_reset(RK_BROWN_OUT, 1'b0);
        rd(9'h08e, 8'h12);
        rd(9'h01e, 8'h5a);
        rd(9'h085, 8'hff);
        rd(9'h08f, 8'h60);
        rd(9'h098, 8'h02);
        rd(9'h105, 8'h08);
        rd(9'h095, 8'hff);
        wr(9'h08e, 8'h01);
        do_reset(RK_EXT_PIN, 1'b0);
        rd(9'h08e, 8'h01);
        do_reset(RK_WATCHDOG, 1'b0);
        rd(9'h08e, 8'h01);
        do_reset(RK_BROWN_OUT, 1'b1);
        rd(9'h08e, 8'h10);
        rd(9'h01e, 8'h00);
        report_and_stop();
    end
endmodule
